// [verilog/genset_start_stop_sequencer.sv]
// Engine-generator start/stop sequencer with AHB-Lite register slave
//
// Contract
// R01: Manual start only on start button
// R02: Stop mode never starts, ignores requests
// R03: Manual start energises fuel and cranks
// R04: No fire: rest, then crank again
// R05: Attempts exhausted: abort, flag fail-to-start
// R06: Release starter on firing, selectable source
// R07: Oil pressure may release starter only
// R08: Safety delay masks listed faults
// R09: Load transfer off until generator available
// R10: Manual: load switch needs loading request
// R11: Loading request sources per breaker control
// R12: Manual on-load holds until open button
// R13: Load inhibit opens switch without ramp
// R14: Stop button drops load, stops at once
// R15: Manual to auto honours auto timers
// R16: Panel lock blocks mode changes
// R17: Auto start request sources
// R18: Start delay; requests gone returns standby
// R19: Request at delay end starts cranking
// R20: Auto running closes switch if configured
// R21: Requests removed starts return delay
// R22: Return expiry ramps off, starts cooling
// R23: Request during cooling returns on load
// R24: Cooling expiry stops the set
// R25: Timers loadable, common time base
//
// The AHB-Lite interface to the registers and the address map are this design's own decisions.
`timescale 1ns/10ps

module genset_start_stop_sequencer
	import genset_seq_pkg::*;
#(
	parameter int TW = 16    // Timer width in bits
)
(
	input wire logic ref_clk_i,
	input wire logic rst_i,
	// AHB-Lite slave
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	// Operator panel and request pins
	input wire logic btn_stop_i,
	input wire logic btn_manual_i,
	input wire logic btn_auto_i,
	input wire logic btn_start_i,
	input wire logic btn_close_i,
	input wire logic btn_open_i,
	input wire logic panel_lock_i,
	input wire logic sched_run_i,
	input wire logic sched_on_load_i,
	input wire logic rs_on_load_i,
	input wire logic rs_load_demand_i,
	input wire logic rs_off_load_i,
	input wire logic paralleling_peer_link_i,
	input wire logic telemetry_req_i,
	// Engine side sensing
	input wire logic fire_alt_freq_i,
	input wire logic fire_pickup_i,
	input wire logic fire_can_i,
	input wire logic oil_rising_i,
	input wire logic gen_available_i,
	input wire logic load_inhibit_i,
	// Engine side drive
	output logic fuel_o,
	output logic starter_o,
	output logic load_close_o,
	output logic delayed_load_o,
	output logic fault_mask_o,
	output logic fail_start_o,
	output logic [1:0] mode_o
);

	// Elaboration check: timers must fit the 32-bit data bus
	if (TW < 4 || TW > 32)
	begin
		$error("TW out of range");
	end

	// ****************************************
	// Input synchronisers
	// ****************************************
	localparam int NIN = 20;
	logic [NIN-1:0] pins_raw;
	logic [NIN-1:0] sync1_q;   // First stage, read only by second
	logic [NIN-1:0] sync2_q;   // Safe to use
	logic [NIN-1:0] prev_q;    // For button edges

	assign pins_raw = {btn_stop_i, btn_manual_i, btn_auto_i, btn_start_i,
		btn_close_i, btn_open_i, panel_lock_i, sched_run_i,
		sched_on_load_i, rs_on_load_i, rs_load_demand_i, rs_off_load_i,
		paralleling_peer_link_i, telemetry_req_i, fire_alt_freq_i,
		fire_pickup_i, fire_can_i, oil_rising_i, gen_available_i,
		load_inhibit_i};

	// Two stages for every pin input
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			sync1_q <= '0;
			sync2_q <= '0;
			prev_q <= '0;
		end
		else
		begin
			sync1_q <= pins_raw;
			sync2_q <= sync1_q;
			prev_q <= sync2_q;
		end
	end

	logic [NIN-1:0] rise;
	assign rise = sync2_q & ~prev_q;

	// Named views of synchronised pins
	logic p_stop, p_man, p_auto, p_start, p_close, p_open, lock;
	logic sched, sched_ol, rs_ol, rs_ld, rs_off, peer, tele;
	logic f_alt, f_pick, f_can, oil, avail, inhibit;
	assign p_stop = rise[19];
	assign p_man = rise[18];
	assign p_auto = rise[17];
	assign p_start = rise[16];
	assign p_close = rise[15];
	assign p_open = rise[14];
	assign lock = sync2_q[13];
	assign sched = sync2_q[12];
	assign sched_ol = sync2_q[11];
	assign rs_ol = sync2_q[10];
	assign rs_ld = sync2_q[9];
	assign rs_off = sync2_q[8];
	assign peer = sync2_q[7];
	assign tele = sync2_q[6];
	assign f_alt = sync2_q[5];
	assign f_pick = sync2_q[4];
	assign f_can = sync2_q[3];
	assign oil = sync2_q[2];
	assign avail = sync2_q[1];
	assign inhibit = sync2_q[0];

	// ****************************************
	// Configuration registers
	// ****************************************
	logic [31:0] ctrl_q;
	logic [TW-1:0] start_dly_q, crank_q, rest_q, safety_q, ret_q, cool_q;
	logic [3:0] attempts_q;
	logic [31:0] tick_div_q;

	// ****************************************
	// AHB-Lite address phase capture
	// ****************************************
	logic ph_wr_q, ph_rd_q;
	logic [7:0] ph_addr_q;
	logic take;
	assign take = hsel_i && hready_i && htrans_i == HTRANS_NONSEQ;

	// Latch address phase; slave answers with zero wait states
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			ph_wr_q <= 1'b0;
			ph_rd_q <= 1'b0;
			ph_addr_q <= 8'h00;
		end
		else
		begin
			ph_wr_q <= take && hwrite_i && hsize_i == HSIZE_WORD;
			ph_rd_q <= take && !hwrite_i;
			ph_addr_q <= haddr_i[7:0];
		end
	end

	// Sequencer state (declared ahead of read mux)
	seq_t st_q;
	mode_t mode_q;
	logic [TW-1:0] tmr_q;
	logic [3:0] tries_q;
	logic fail_q, on_load_q;

	// Register writes, data phase
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			ctrl_q <= CTRL_RST;
			start_dly_q <= TW'(START_DLY_RST);
			crank_q <= TW'(CRANK_RST);
			rest_q <= TW'(REST_RST);
			attempts_q <= ATTEMPTS_RST;
			safety_q <= TW'(SAFETY_RST);
			ret_q <= TW'(RETURN_RST);
			cool_q <= TW'(COOL_RST);
			tick_div_q <= TICK_RST;
		end
		else if (ph_wr_q)
		begin
			case (ph_addr_q)   // R25
				OFS_CTRL: ctrl_q <= hwdata_i;
				OFS_START_DLY: start_dly_q <= hwdata_i[TW-1:0];
				OFS_CRANK: crank_q <= hwdata_i[TW-1:0];
				OFS_REST: rest_q <= hwdata_i[TW-1:0];
				OFS_ATTEMPTS: attempts_q <= hwdata_i[3:0];
				OFS_SAFETY: safety_q <= hwdata_i[TW-1:0];
				OFS_RETURN: ret_q <= hwdata_i[TW-1:0];
				OFS_COOL: cool_q <= hwdata_i[TW-1:0];
				OFS_TICK: tick_div_q <= hwdata_i;
				default: ;   // Unmapped writes are dropped
			endcase
		end
	end

	// Read data registered in the address-phase cycle's successor
	logic [31:0] rd_mux;
	always_comb
	begin
		case (haddr_i[7:0])
			OFS_CTRL: rd_mux = ctrl_q;
			OFS_START_DLY: rd_mux = 32'(start_dly_q);
			OFS_CRANK: rd_mux = 32'(crank_q);
			OFS_REST: rd_mux = 32'(rest_q);
			OFS_ATTEMPTS: rd_mux = 32'(attempts_q);
			OFS_SAFETY: rd_mux = 32'(safety_q);
			OFS_RETURN: rd_mux = 32'(ret_q);
			OFS_COOL: rd_mux = 32'(cool_q);
			OFS_TICK: rd_mux = tick_div_q;
			OFS_STATUS: rd_mux = {20'h0_0000, tries_q, on_load_q, fail_q,
				2'(mode_q), 4'(st_q)};
			default: rd_mux = 32'h0000_0000;   // Unmapped reads zero
		endcase
	end

	// Bus outputs from flops; always OKAY, never waits
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			hrdata_o <= 32'h0000_0000;
			hreadyout_o <= 1'b1;
			hresp_o <= 1'b0;
		end
		else
		begin
			hrdata_o <= take && !hwrite_i ? rd_mux : 32'h0000_0000;
			hreadyout_o <= 1'b1;
			hresp_o <= 1'b0;
		end
	end

	// ****************************************
	// Common time base
	// ****************************************
	logic [31:0] div_q;
	logic tick_q;
	// One tick every tick_div_q clocks feeds all timers
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			div_q <= 32'h0000_0000;
			tick_q <= 1'b0;
		end
		else if (div_q + 32'h0000_0001 >= tick_div_q)
		begin
			div_q <= 32'h0000_0000;
			tick_q <= 1'b1;   // R25
		end
		else
		begin
			div_q <= div_q + 32'h0000_0001;
			tick_q <= 1'b0;
		end
	end

	// ****************************************
	// Request decode
	// ****************************************
	logic auto_req, load_req, fired;
	// Any automatic start source
	assign auto_req = sched | rs_ol | rs_ld | rs_off | peer | tele; // R17
	// Loading requests; all only count without manual breaker control
	assign load_req = !ctrl_q[CTRL_MAN_BRK] &&
		(sched_ol | rs_ol | rs_ld | peer | tele);   // R11
	// Firing sources; oil only releases starter, never speed sensing
	assign fired = f_alt | (ctrl_q[CTRL_USE_PICKUP] & f_pick) |
		(ctrl_q[CTRL_USE_CAN] & f_can) |
		(ctrl_q[CTRL_USE_OIL] & oil);   // R06 R07

	// ****************************************
	// Mode selection
	// ****************************************
	// Buttons change mode unless panel locked
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
			mode_q <= MODE_STOP;
		else if (!lock)   // R16
		begin
			if (p_stop)
				mode_q <= MODE_STOP;
			else if (p_man)
				mode_q <= MODE_MANUAL;
			else if (p_auto)
				mode_q <= MODE_AUTO;   // R15
		end
	end

	logic timer_done;
	assign timer_done = tmr_q == '0;

	// ****************************************
	// Start/stop sequence
	// ****************************************
	// Stop mode forces idle, no fuel; timers count on ticks
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			st_q <= ST_IDLE;
			tmr_q <= '0;
			tries_q <= 4'h0;
			fail_q <= 1'b0;
		end
		else if (mode_q == MODE_STOP)
		begin
			st_q <= ST_IDLE;   // R02 R14
			tmr_q <= '0;
			tries_q <= 4'h0;
			fail_q <= 1'b0;   // Entering stop clears the fail latch
		end
		else
		begin
			if (tick_q && !timer_done)
				tmr_q <= tmr_q - 1'b1;
			case (st_q)
				ST_IDLE:
				begin
					if (mode_q == MODE_MANUAL && p_start)
					begin
						st_q <= ST_CRANK;   // R01 R03
						tmr_q <= crank_q;
						tries_q <= 4'h1;
						fail_q <= 1'b0;
					end
					else if (mode_q == MODE_AUTO && auto_req)
					begin
						st_q <= ST_START_DLY;   // R18
						tmr_q <= start_dly_q;
						tries_q <= 4'h0;
					end
				end
				ST_START_DLY:
				begin
					if (!auto_req || mode_q != MODE_AUTO)
						st_q <= ST_IDLE;   // R18
					else if (timer_done)
					begin
						st_q <= ST_CRANK;   // R19
						tmr_q <= crank_q;
						tries_q <= 4'h1;
						fail_q <= 1'b0;
					end
				end
				ST_CRANK:
				begin
					if (fired)
					begin
						st_q <= ST_SAFETY;   // R06 R08
						tmr_q <= safety_q;
					end
					else if (timer_done)
					begin
						if (tries_q >= attempts_q)
						begin
							st_q <= ST_FAIL;   // R05
							fail_q <= 1'b1;
						end
						else
						begin
							st_q <= ST_REST;   // R04
							tmr_q <= rest_q;
						end
					end
				end
				ST_REST:
				begin
					if (timer_done)
					begin
						st_q <= ST_CRANK;   // R04
						tmr_q <= crank_q;
						tries_q <= tries_q + 4'h1;
					end
				end
				ST_SAFETY:
				begin
					if (timer_done)
						st_q <= ST_RUN;   // R08
				end
				ST_RUN:
				begin
					if (mode_q == MODE_AUTO && !auto_req)
					begin
						st_q <= ST_RETURN;   // R21
						tmr_q <= ret_q;
					end
				end
				ST_RETURN:
				begin
					if (mode_q != MODE_AUTO || auto_req)
						st_q <= ST_RUN;
					else if (timer_done)
					begin
						st_q <= ST_COOL;   // R22
						tmr_q <= cool_q;
					end
				end
				ST_COOL:
				begin
					if (mode_q != MODE_AUTO || auto_req)
						st_q <= ST_RUN;   // R23
					else if (timer_done)
						st_q <= ST_IDLE;   // R24
				end
				ST_FAIL:
					st_q <= ST_FAIL;   // Held until stop mode
				default:
					st_q <= ST_IDLE;
			endcase
		end
	end

	// ****************************************
	// Load switch control
	// ****************************************
	logic running;
	assign running = (st_q == ST_RUN || st_q == ST_RETURN) && avail;

	// Closes only when available; inhibit opens without ramp
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
			on_load_q <= 1'b0;
		else if (!running || inhibit || mode_q == MODE_STOP)
			on_load_q <= 1'b0;   // R09 R13 R14 R22
		else if (mode_q == MODE_MANUAL)
		begin
			if (!on_load_q && (p_close || load_req))
				on_load_q <= 1'b1;   // R10 R11
			else if (on_load_q && p_open &&
				(!load_req || ctrl_q[CTRL_MAN_BRK]))
				on_load_q <= 1'b0;   // R12
		end
		else   // Held through return delay; cooling opens it
			on_load_q <= ctrl_q[CTRL_AUTO_LOAD];   // R20 R21
	end

	// ****************************************
	// Output flops
	// ****************************************
	// All engine drive straight from flops
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			fuel_o <= 1'b0;
			starter_o <= 1'b0;
			load_close_o <= 1'b0;
			delayed_load_o <= 1'b0;
			fault_mask_o <= 1'b0;
			fail_start_o <= 1'b0;
			mode_o <= 2'h0;
		end
		else
		begin
			fuel_o <= st_q inside {ST_CRANK, ST_REST, ST_SAFETY, ST_RUN,
				ST_RETURN, ST_COOL};   // R03 R19
			starter_o <= st_q == ST_CRANK && !fired;   // R04 R06
			load_close_o <= on_load_q;   // R09
			delayed_load_o <= on_load_q && mode_q != MODE_STOP;   // R14
			fault_mask_o <= st_q inside {ST_CRANK, ST_REST, ST_SAFETY}; // R08
			fail_start_o <= fail_q;   // R05
			mode_o <= 2'(mode_q);
		end
	end

endmodule

// [verilog/genset_seq_pkg.sv]
// Package of register map, field layout and timing constants for sequencer
package genset_seq_pkg;

	// ****************************************
	// Register offsets (byte addresses)
	// ****************************************
	localparam logic [7:0] OFS_CTRL = 8'h00;   // Firing source and load switch options
	localparam logic [7:0] OFS_START_DLY = 8'h04;
	localparam logic [7:0] OFS_CRANK = 8'h08;
	localparam logic [7:0] OFS_REST = 8'h0C;
	localparam logic [7:0] OFS_ATTEMPTS = 8'h10;
	localparam logic [7:0] OFS_SAFETY = 8'h14;
	localparam logic [7:0] OFS_RETURN = 8'h18;
	localparam logic [7:0] OFS_COOL = 8'h1C;
	localparam logic [7:0] OFS_STATUS = 8'h20;
	localparam logic [7:0] OFS_TICK = 8'h24;   // Time base divider

	// ****************************************
	// Control register fields
	// ****************************************
	localparam int CTRL_USE_PICKUP = 0;   // Flywheel pickup fires
	localparam int CTRL_USE_CAN = 1;      // Engine link fires
	localparam int CTRL_USE_OIL = 2;      // Rising oil pressure fires
	localparam int CTRL_MAN_BRK = 3;      // Manual breaker control
	localparam int CTRL_AUTO_LOAD = 4;    // Close load switch in auto

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [31:0] CTRL_RST = 32'h0000_0010;
	localparam logic [15:0] START_DLY_RST = 16'h0005;
	localparam logic [15:0] CRANK_RST = 16'h000A;
	localparam logic [15:0] REST_RST = 16'h000A;
	localparam logic [3:0] ATTEMPTS_RST = 4'h3;
	localparam logic [15:0] SAFETY_RST = 16'h000A;
	localparam logic [15:0] RETURN_RST = 16'h001E;
	localparam logic [15:0] COOL_RST = 16'h003C;
	localparam logic [31:0] TICK_RST = 32'h0000_C350; // 1 ms at 50 MHz

	// ****************************************
	// Modes and sequence states
	// ****************************************
	typedef enum logic [1:0]
	{
		MODE_STOP,
		MODE_MANUAL,
		MODE_AUTO
	} mode_t;

	typedef enum logic [3:0]
	{
		ST_IDLE,
		ST_START_DLY,
		ST_CRANK,
		ST_REST,
		ST_SAFETY,
		ST_RUN,
		ST_RETURN,
		ST_COOL,
		ST_FAIL
	} seq_t;

	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] HSIZE_WORD = 3'h2;

endpackage

// [tb/genset_seq_props.sv]
// Checker of sequencer port relations, bound to the top module
`timescale 1ns/10ps

module genset_seq_props
(
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic panel_lock_i,
	input wire logic load_inhibit_i,
	input wire logic fire_alt_freq_i,
	input wire logic gen_available_i,
	input wire logic fuel_o,
	input wire logic starter_o,
	input wire logic load_close_o,
	input wire logic fault_mask_o,
	input wire logic fail_start_o,
	input wire logic [1:0] mode_o
);
	// ***
	// One clock domain
	// ***
	default clocking dc @(posedge ref_clk_i);
	endclocking
	default disable iff (rst_i);
	// Starter never turns a dry engine
	property p_crank_fuel;
		starter_o |-> fuel_o;
	endproperty
	a_crank_fuel: assert property (p_crank_fuel)
		else $error("starter without fuel");
	// Settled stop mode keeps the set dead
	property p_stop_idle;
		(mode_o == 2'h0) [*4] |-> !fuel_o && !starter_o;
	endproperty
	a_stop_idle: assert property (p_stop_idle)
		else $error("set running in stop mode");
	// Aborted start leaves everything off
	property p_fail_quiet;
		fail_start_o |-> !fuel_o && !starter_o;
	endproperty
	a_fail_quiet: assert property (p_fail_quiet)
		else $error("drive active after failed start");
	// Sync chain allows a few cycles before release
	property p_fire_release;
		(starter_o && fire_alt_freq_i) [*3] |-> ##[0:4] !starter_o;
	endproperty
	a_fire_release: assert property (p_fire_release)
		else $error("starter held after firing");
	// Rest or safety delay follows every starter drop with fuel still on
	property p_mask_after;
		$fell(starter_o) && fuel_o |-> fault_mask_o;
	endproperty
	a_mask_after: assert property (p_mask_after)
		else $error("faults unmasked after crank");
	// Closing needs a settled available generator
	property p_avail_close;
		$rose(load_close_o) |-> gen_available_i && $past(gen_available_i, 2);
	endproperty
	a_avail_close: assert property (p_avail_close)
		else $error("load closed while unavailable");
	// Inhibit opens without ramp
	property p_inhibit;
		load_inhibit_i [*5] |-> !load_close_o;
	endproperty
	a_inhibit: assert property (p_inhibit)
		else $error("load closed under inhibit");
	// Lock freezes mode
	property p_lock;
		panel_lock_i [*5] |-> $stable(mode_o);
	endproperty
	a_lock: assert property (p_lock)
		else $error("mode changed while locked");
endmodule

bind genset_start_stop_sequencer genset_seq_props u_props
(
	.ref_clk_i(ref_clk_i), .rst_i(rst_i), .panel_lock_i(panel_lock_i),
	.load_inhibit_i(load_inhibit_i), .fire_alt_freq_i(fire_alt_freq_i),
	.gen_available_i(gen_available_i), .fuel_o(fuel_o),
	.starter_o(starter_o), .load_close_o(load_close_o),
	.fault_mask_o(fault_mask_o), .fail_start_o(fail_start_o),
	.mode_o(mode_o)
);

// [tb/genset_engine_model.sv]
// Behavioural engine: fires after a crank time, then warms up
`timescale 1ns/10ps

module genset_engine_model
(
	input wire logic clk_i,
	input wire logic fuel_i,
	input wire logic starter_i,
	input wire logic [7:0] fire_after_i,   // Crank cycles, 0 never fires
	input wire logic [1:0] src_i,   // Firing sign: alt, pickup, link, oil
	output logic alt_o,
	output logic pickup_o,
	output logic can_o,
	output logic oil_o,
	output logic avail_o
);
	logic [7:0] crank_q;   // Crank cycles so far
	logic run_q;   // Engine has fired
	logic [3:0] warm_q;   // Run-up before output is usable
	// Fires only when cranked with fuel, dies when fuel drops
	always_ff @(posedge clk_i)
	begin
		if (!fuel_i)
		begin
			crank_q <= 8'h00;
			run_q <= 1'h0;
		end
		else if (starter_i && fire_after_i != 8'h00)
		begin
			crank_q <= crank_q + 8'h01;
			if (crank_q + 8'h01 >= fire_after_i)
				run_q <= 1'h1;
		end
	end
	// Output only usable some cycles after firing
	always_ff @(posedge clk_i)
		warm_q <= !run_q ? 4'h0 : (warm_q == 4'hF ? warm_q : warm_q + 4'h1);
	// One sign of firing at a time, so each source is really exercised
	assign alt_o = run_q && src_i == 2'h0;
	assign pickup_o = run_q && src_i == 2'h1;
	assign can_o = run_q && src_i == 2'h2;
	assign oil_o = run_q && src_i == 2'h3;
	assign avail_o = warm_q == 4'hF;
endmodule

// [tb/test_genset_start_stop_sequencer.sv]
// Self-checking bench for the start/stop sequencer
`timescale 1ns/10ps

module test_genset_start_stop_sequencer
	import genset_seq_pkg::*;
;
	// ***
	// Stimulus and observed nets
	// ***
	logic clk = 1'h0, rst = 1'h1, hsel = 1'h0, hwrite = 1'h0;
	logic lock = 1'h0, inhibit = 1'h0, rd_ph = 1'h0, st_prev = 1'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, sd;
	logic [1:0] htrans = 2'h0, src = 2'h0;
	logic [2:0] hsize = 3'h0;
	logic [5:0] btn = 6'h00;   // Stop, manual, auto, start, close, open
	logic [6:0] req = 7'h00;   // Level start and loading requests
	logic [7:0] fire_after = 8'h03;
	wire logic hrdy, fuel, starter, close, fmask, fail, alt, pick, can, oil;
	wire logic avail, dload, hresp;
	wire logic [31:0] hrdata;
	wire logic [1:0] mode;
	logic [31:0] exp_q[$];   // Expected read data, oldest first
	logic [31:0] msk_q[$];   // Compared bits of each read
	int num_errors = 0, num_checks = 0, cyc = 0, ncr = 0;
	int auto_src[6] = '{0, 2, 3, 4, 5, 6};   // Auto start sources

	genset_start_stop_sequencer uut
	(
		.ref_clk_i(clk), .rst_i(rst), .hsel_i(hsel), .haddr_i(haddr),
		.htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize),
		.hwdata_i(hwdata), .hready_i(hrdy), .hrdata_o(hrdata),
		.hreadyout_o(hrdy), .hresp_o(hresp), .btn_stop_i(btn[0]),
		.btn_manual_i(btn[1]), .btn_auto_i(btn[2]), .btn_start_i(btn[3]),
		.btn_close_i(btn[4]), .btn_open_i(btn[5]), .panel_lock_i(lock),
		.sched_run_i(req[0]), .sched_on_load_i(req[1]),
		.rs_on_load_i(req[2]), .rs_load_demand_i(req[3]),
		.rs_off_load_i(req[4]), .paralleling_peer_link_i(req[5]),
		.telemetry_req_i(req[6]), .fire_alt_freq_i(alt),
		.fire_pickup_i(pick), .fire_can_i(can), .oil_rising_i(oil),
		.gen_available_i(avail), .load_inhibit_i(inhibit), .fuel_o(fuel),
		.starter_o(starter), .load_close_o(close), .delayed_load_o(dload),
		.fault_mask_o(fmask), .fail_start_o(fail), .mode_o(mode)
	);

	genset_engine_model engine
	(
		.clk_i(clk), .fuel_i(fuel), .starter_i(starter),
		.fire_after_i(fire_after), .src_i(src), .alt_o(alt),
		.pickup_o(pick), .can_o(can), .oil_o(oil), .avail_o(avail)
	);

	// ***
	// Shared tasks
	// ***
	always #10 clk = ~clk;

	task check(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task summarize();
		$display("checks %0d mismatches %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Single word transfer; for reads d is the expected data
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [31:0] m);
		@(posedge clk);
		hsel <= 1'h1;
		htrans <= HTRANS_NONSEQ;
		haddr <= {24'h0, a};
		hwrite <= w;
		hsize <= HSIZE_WORD;
		if (!w)
		begin
			exp_q.push_back(d & m);
			msk_q.push_back(m);
		end
		do @(posedge clk); while (hrdy !== 1'h1);
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= d;
		rd_ph <= !w;
		do @(posedge clk); while (hrdy !== 1'h1);
		rd_ph <= 1'h0;
	endtask

	// Button held long enough to pass the input sync
	task press(input int i);
		@(posedge clk);
		btn[i] <= 1'h1;
		repeat (3) @(posedge clk);
		btn[i] <= 1'h0;
	endtask

	function automatic logic [6:0] outs();
		return {fuel, starter, fmask, close, fail, mode};
	endfunction

	task automatic wait_vec(input logic [6:0] e, input logic [6:0] m);
		int n;
		n = 0;
		while ((outs() & m) !== e && n < 4000)
		begin
			@(posedge clk);
			n++;
		end
		check({25'h0, outs() & m}, {25'h0, e});
	endtask

	task automatic hold_vec(input logic [6:0] e, input logic [6:0] m,
		input int c);
		logic ok;
		ok = 1'h1;
		repeat (c)
		begin
			@(posedge clk);
			if ((outs() & m) !== e)
				ok = 1'h0;
		end
		check({31'h0, ok}, 32'h1);
	endtask

	// Read data compared in the data phase, oldest note first
	always @(posedge clk)
		if (rd_ph)
		begin
			check(hrdata & msk_q[0], exp_q.pop_front());
			check({31'h0, hresp}, 32'h0);
			void'(msk_q.pop_front());
		end

	// Crank attempt counter and run limit
	always @(posedge clk)
	begin
		st_prev <= starter;
		if (starter === 1'h1 && st_prev === 1'h0)
			ncr++;
		cyc++;
		if (cyc == 30000)
		begin
			num_errors++;
			summarize();
		end
	end

	// ***
	// Scenarios
	// ***
	initial
	begin
		void'($urandom(32'hCA23B3D7));
		repeat (4) @(posedge clk);
		rst <= 1'h0;
		bus(1'h0, OFS_CTRL, CTRL_RST, 32'hFFFF_FFFF);
		bus(1'h0, OFS_COOL, {16'h0, COOL_RST}, 32'h0000_FFFF);
		bus(1'h0, 8'h40, 32'h0, 32'hFFFF_FFFF);
		bus(1'h0, OFS_STATUS, 32'h0, 32'h0000_007F);
		sd = 32'h10 + $urandom_range(8, 0);
		bus(1'h1, OFS_TICK, 32'h1, 32'h0);
		bus(1'h1, OFS_START_DLY, sd, 32'h0);
		bus(1'h1, OFS_CRANK, 32'h8, 32'h0);
		bus(1'h1, OFS_REST, 32'h6, 32'h0);
		bus(1'h1, OFS_ATTEMPTS, 32'h2, 32'h0);
		bus(1'h1, OFS_SAFETY, 32'hA, 32'h0);
		bus(1'h1, OFS_RETURN, 32'hF, 32'h0);
		bus(1'h1, OFS_COOL, 32'h14, 32'h0);
		bus(1'h1, OFS_CTRL, 32'h17, 32'h0);
		bus(1'h0, OFS_START_DLY, sd, 32'h0000_FFFF);
		$display("registers done");
		req[2] <= 1'h1;
		press(3);
		hold_vec(7'h00, 7'h60, 40);
		req <= 7'h00;
		lock <= 1'h1;
		press(1);
		hold_vec(7'h00, 7'h03, 20);
		lock <= 1'h0;
		$display("stop and lock done");
		press(1);
		wait_vec(7'h01, 7'h03);
		req[0] <= 1'h1;
		hold_vec(7'h01, 7'h63, 40);
		req <= 7'h00;
		fire_after <= 8'h00;
		ncr = 0;
		press(3);
		wait_vec(7'h60, 7'h60);
		wait_vec(7'h04, 7'h64);
		check(ncr, 32'h2);
		press(0);
		wait_vec(7'h00, 7'h07);
		$display("failed start done");
		press(1);
		src <= 2'($urandom_range(3, 0));
		fire_after <= 8'(2 + $urandom_range(3, 0));
		press(3);
		wait_vec(7'h51, 7'h73);
		wait_vec(7'h41, 7'h73);
		bus(1'h0, OFS_STATUS, 32'h15, 32'h0000_003F);
		hold_vec(7'h40, 7'h48, 30);
		req[3] <= 1'h1;
		wait_vec(7'h48, 7'h48);
		req <= 7'h00;
		hold_vec(7'h48, 7'h48, 20);
		press(5);
		wait_vec(7'h40, 7'h48);
		press(4);
		wait_vec(7'h48, 7'h48);
		inhibit <= 1'h1;
		wait_vec(7'h40, 7'h48);
		inhibit <= 1'h0;
		press(4);
		wait_vec(7'h48, 7'h48);
		check({31'h0, dload}, 32'h1);
		press(0);
		wait_vec(7'h00, 7'h4B);
		check({31'h0, dload}, 32'h0);
		press(1);
		press(3);
		wait_vec(7'h41, 7'h73);
		press(2);
		wait_vec(7'h42, 7'h43);
		hold_vec(7'h42, 7'h43, 10);
		wait_vec(7'h02, 7'h43);
		$display("manual run done");
		foreach (auto_src[i])
		begin
			src <= 2'(i);
			req[auto_src[i]] <= 1'h1;
			wait_vec(7'h62, 7'h63);
			wait_vec(7'h42, 7'h73);
			req <= 7'h00;
			wait_vec(7'h02, 7'h43);
		end
		req[2] <= 1'h1;
		repeat (6) @(posedge clk);
		req <= 7'h00;
		hold_vec(7'h00, 7'h60, 60);
		req[2] <= 1'h1;
		wait_vec(7'h48, 7'h48);
		req <= 7'h00;
		hold_vec(7'h48, 7'h48, 10);
		wait_vec(7'h40, 7'h48);
		req[2] <= 1'h1;
		wait_vec(7'h48, 7'h48);
		req <= 7'h00;
		wait_vec(7'h00, 7'h40);
		$display("auto run done");
		summarize();
	end
endmodule
